/* File: verilog/tsr_pkg.sv */
// constants for the tdm stream rate and high-impedance control block
package tsr_pkg;
  // word-aligned byte offsets of the registers
  localparam logic [11:0] MAIN_CTRL_OFS = 12'h000;
  localparam logic [11:0] MODE_SEL_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] IN_CTRL_BASE = 12'h100;
  localparam logic [11:0] OUT_CTRL_BASE = 12'h180;
  localparam logic [11:0] CONN_MEM_BASE = 12'h200;
  // main_control_reg fields
  localparam int OSB_BIT = 2;
  localparam int MULT_MODE_BIT = 3;
  localparam int CORE_OSC_BIT = 4;
  localparam int CKIN_LSB = 5;
  localparam logic [15:0] MAIN_CTRL_RST = 16'h0000;
  // internal_mode_sel_reg fields
  localparam int LOW_BIDIR_BIT = 6;
  localparam int HIGH_BIDIR_BIT = 7;
  localparam logic [15:0] MODE_SEL_RST = 16'h0000;
  // stream control fields
  localparam int RATE_LSB = 0;
  localparam logic [15:0] STREAM_CTRL_RST = 16'h0000;
  // stream rate codes, anything else leaves the stream off
  localparam logic [3:0] RATE_2M = 4'h1;
  localparam logic [3:0] RATE_4M = 4'h2;
  localparam logic [3:0] RATE_8M = 4'h3;
  localparam logic [3:0] RATE_16M = 4'h4;
  // connection memory entry fields
  localparam int CM_HIZ_BIT = 15;
  localparam int CM_MSG_BIT = 14;
  localparam int CM_SRC_LSB = 8;
  localparam logic [15:0] CONN_MEM_RST = 16'h8000;
  // status fields
  localparam int STAT_OVER_BIT = 15;
  localparam int STAT_SYNC_BIT = 14;
  localparam int STAT_CORE_BIT = 13;
  // channel figures
  localparam int BASE_CHANNELS = 32;
  localparam logic [13:0] CHANNEL_BUDGET = 14'h0800;
  // frame timing
  localparam int FRAME_NS = 125000;
  localparam int CLK_NS = 100;
  localparam int FRAME_CYCLES = FRAME_NS / CLK_NS;
  // core clock figures in kHz, reported as status only
  localparam int CORE_CKI_KHZ = 98304;
  localparam int CORE_OSC_KHZ = 100000;
endpackage : tsr_pkg

/* File: verilog/tsr_stream_ctrl.sv */
// stream rate, bidirectional grouping, message mode and high-impedance control
`timescale 1ns/1ps
// Summary of operation
// RULE1: every input and output stream runs at 2.048, 4.096, 8.192 or 16.384 Mbps.
// RULE2: a frame holds 32, 64, 128 or 256 channels per stream by rate.
// RULE3: low bidir bit ties inputs 0-15 low, outputs 0-15 become two-way pins.
// RULE4: high bidir bit ties inputs 16-31 low, outputs 16-31 become two-way pins.
// RULE5: the two bidir groups are set independently of each other.
// RULE6: input rate comes from bits 3-0 of each stream's input control register.
// RULE7: output rate comes from bits 3-0 of each stream's output control register.
// RULE8: output rates may differ from input rates; data is rate converted.
// RULE9: software keeps the switched channel total at or below 2048.
// RULE10: capacity counts whole streams only; no fractional streams.
// RULE11: sixteen high-impedance control outputs serve output streams 0-15 only.
// RULE12: each control output gives one timeslot per channel, one channel long.
// RULE13: control outputs act only with drive enable pin and standby bit high.
// RULE14: enable pin, standby bit or reset low: controls high, outputs off.
// RULE15: an unused high-impedance channel drives its control output high.
// RULE16: message mode sends host-written memory bytes on the chosen channel.
// RULE17: frame pulse and input clock set the frame boundary and sampling.
// RULE18: divided slave outputs run from input clock at half its rate at most.
// RULE19: divided slave core clock is 98.304 MHz from input or 100 MHz oscillator.
// RULE20: multiplied slave mode drives outputs from internal 16.384 MHz at any rate; here outputs keep input clock timing, only the rate limit is lifted.
// RULE21: configuration goes through a 16-bit data, 14-bit address host port.
// RULE22: four fixed rate codes; unused codes leave the stream disabled.
module tsr_stream_ctrl #(
  parameter int NUM_STREAMS = 32,
  parameter int NUM_HIZ = 16,
  parameter int CM_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  // classic wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic [13:0] wbAdr,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // stream timing
  input wire logic inputBitClock,
  input wire logic framePulseIn,
  input wire logic outputDriveEnablePin,
  // serial streams
  input wire logic [NUM_STREAMS-1:0] serialInStreams,
  input wire logic [NUM_STREAMS-1:0] serialOutStreamsIn,
  output logic [NUM_STREAMS-1:0] serialOutStreams,
  output logic [NUM_STREAMS-1:0] serialOutStreamsOe,
  output logic [NUM_HIZ-1:0] extHizCtrlOutputs
);
  localparam int CMW = $clog2(CM_DEPTH);
  localparam int HALF = NUM_STREAMS / 2;

  typedef enum logic [1:0] {FS_HUNT = 2'b01, FS_LOCK = 2'b10} tsr_frame_t;

  // rate code to {valid, rate index 0..3}
  function automatic logic [2:0] rateDec(input logic [3:0] code);
    if (code == tsr_pkg::RATE_2M) begin
      rateDec = 3'h4;
    end else if (code == tsr_pkg::RATE_4M) begin
      rateDec = 3'h5;
    end else if (code == tsr_pkg::RATE_8M) begin
      rateDec = 3'h6;
    end else if (code == tsr_pkg::RATE_16M) begin
      rateDec = 3'h7;
    end else begin
      rateDec = 3'h0; // [RULE22]
    end
  endfunction : rateDec

  // register state
  logic [15:0] mainControlReg, next_mainControlReg;
  logic [15:0] internalModeSelReg, next_internalModeSelReg;
  logic [15:0] streamInCtrlRegs [NUM_STREAMS];
  logic [15:0] next_streamInCtrlRegs [NUM_STREAMS];
  logic [15:0] streamOutCtrlRegs [NUM_STREAMS];
  logic [15:0] next_streamOutCtrlRegs [NUM_STREAMS];
  logic [15:0] connMem [CM_DEPTH];
  logic [15:0] next_connMem [CM_DEPTH];
  logic [31:0] next_wbDatO;
  logic next_wbAck;
  logic overBudget, next_overBudget;
  logic [13:0] chanTotal;
  logic [2:0] inRateDec [NUM_STREAMS];

  // frame timing state
  tsr_frame_t frameState, next_frameState;
  logic [10:0] framePos, next_framePos;
  logic ckiPrev;
  logic ckiEdge;
  logic [1:0] ckinSel;
  logic [11:0] posStep;

  // data path state
  logic [7:0] dataMem [NUM_STREAMS*CM_DEPTH];
  logic [7:0] inShift [NUM_STREAMS];
  logic [7:0] next_inShift [NUM_STREAMS];
  logic [NUM_STREAMS-1:0] memWr;
  logic [7:0] memWrByte [NUM_STREAMS];
  logic [CMW-1:0] memWrIdx [NUM_STREAMS];
  logic [NUM_STREAMS-1:0] inEff;
  logic [NUM_STREAMS-1:0] chanHiz;
  logic [NUM_STREAMS-1:0] outBit;
  logic [NUM_STREAMS-1:0] outOk;
  logic [7:0] outChan [NUM_STREAMS];
  logic [NUM_STREAMS-1:0] next_serialOutStreams;
  logic [NUM_STREAMS-1:0] next_serialOutStreamsOe;
  logic [NUM_HIZ-1:0] next_extHizCtrlOutputs;
  logic drvEnable;
  logic lowBidir, highBidir, multMode;

  assign ckinSel = (mainControlReg[tsr_pkg::CKIN_LSB +: 2] == 2'b11) ? 2'b00 :
                   mainControlReg[tsr_pkg::CKIN_LSB +: 2];
  assign posStep = 12'h001 << ckinSel;
  assign ckiEdge = inputBitClock & ~ckiPrev;
  assign lowBidir = internalModeSelReg[tsr_pkg::LOW_BIDIR_BIT];
  assign highBidir = internalModeSelReg[tsr_pkg::HIGH_BIDIR_BIT];
  assign multMode = mainControlReg[tsr_pkg::MULT_MODE_BIT];
  // drive gate from pin, standby bit and reset
  assign drvEnable = rst_n & outputDriveEnablePin &
                     mainControlReg[tsr_pkg::OSB_BIT]; // [RULE13] [RULE14]

  // register writes, read mux and bus answer
  always_comb begin
    next_mainControlReg = mainControlReg;
    next_internalModeSelReg = internalModeSelReg;
    next_streamInCtrlRegs = streamInCtrlRegs;
    next_streamOutCtrlRegs = streamOutCtrlRegs;
    next_connMem = connMem;
    next_wbDatO = 32'h00000000;
    next_wbAck = wbCyc & wbStb & ~wbAck;
    if (wbCyc && wbStb && !wbAck) begin // [RULE21]
      if (wbAdr[13:2] == {2'b00, tsr_pkg::MAIN_CTRL_OFS[11:2]}) begin
        next_wbDatO[15:0] = mainControlReg;
        if (wbWe && wbSel[0]) next_mainControlReg[7:0] = wbDatI[7:0];
        if (wbWe && wbSel[1]) next_mainControlReg[15:8] = wbDatI[15:8];
      end else if (wbAdr[13:2] == {2'b00, tsr_pkg::MODE_SEL_OFS[11:2]}) begin
        next_wbDatO[15:0] = internalModeSelReg;
        if (wbWe && wbSel[0]) next_internalModeSelReg[7:0] = wbDatI[7:0]; // [RULE5]
        if (wbWe && wbSel[1]) next_internalModeSelReg[15:8] = wbDatI[15:8];
      end else if (wbAdr[13:2] == {2'b00, tsr_pkg::STATUS_OFS[11:2]}) begin
        next_wbDatO[15:0] = {overBudget, frameState == FS_LOCK,
                             mainControlReg[tsr_pkg::CORE_OSC_BIT], chanTotal[12:0]}; // [RULE19]
      end else if (wbAdr[13:9] == 5'h00 && wbAdr[8:7] == tsr_pkg::IN_CTRL_BASE[8:7]) begin
        next_wbDatO[15:0] = streamInCtrlRegs[wbAdr[6:2]];
        if (wbWe && wbSel[0]) next_streamInCtrlRegs[wbAdr[6:2]][7:0] = wbDatI[7:0];
        if (wbWe && wbSel[1]) next_streamInCtrlRegs[wbAdr[6:2]][15:8] = wbDatI[15:8];
      end else if (wbAdr[13:9] == 5'h00 && wbAdr[8:7] == tsr_pkg::OUT_CTRL_BASE[8:7]) begin
        next_wbDatO[15:0] = streamOutCtrlRegs[wbAdr[6:2]];
        if (wbWe && wbSel[0]) next_streamOutCtrlRegs[wbAdr[6:2]][7:0] = wbDatI[7:0];
        if (wbWe && wbSel[1]) next_streamOutCtrlRegs[wbAdr[6:2]][15:8] = wbDatI[15:8];
      end else if (wbAdr[13:9] == 5'h01 && wbAdr[8:2] < 7'(CM_DEPTH)) begin
        next_wbDatO[15:0] = connMem[wbAdr[CMW+1:2]];
        if (wbWe && wbSel[0]) next_connMem[wbAdr[CMW+1:2]][7:0] = wbDatI[7:0]; // [RULE16]
        if (wbWe && wbSel[1]) next_connMem[wbAdr[CMW+1:2]][15:8] = wbDatI[15:8];
      end
    end
  end

  // registers and bus answer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mainControlReg <= tsr_pkg::MAIN_CTRL_RST;
      internalModeSelReg <= tsr_pkg::MODE_SEL_RST;
      for (int i = 0; i < NUM_STREAMS; i++) begin
        streamInCtrlRegs[i] <= tsr_pkg::STREAM_CTRL_RST;
        streamOutCtrlRegs[i] <= tsr_pkg::STREAM_CTRL_RST;
      end
      for (int i = 0; i < CM_DEPTH; i++) begin
        connMem[i] <= tsr_pkg::CONN_MEM_RST;
      end
      wbDatO <= 32'h00000000;
      wbAck <= 1'b0;
    end else begin
      mainControlReg <= next_mainControlReg;
      internalModeSelReg <= next_internalModeSelReg;
      streamInCtrlRegs <= next_streamInCtrlRegs;
      streamOutCtrlRegs <= next_streamOutCtrlRegs;
      connMem <= next_connMem;
      wbDatO <= next_wbDatO;
      wbAck <= next_wbAck;
    end
  end

  // whole-stream channel budget over enabled input streams
  always_comb begin
    chanTotal = 14'h0000;
    for (int s = 0; s < NUM_STREAMS; s++) begin
      if (inRateDec[s][2]) begin
        chanTotal = chanTotal + (14'(tsr_pkg::BASE_CHANNELS) << inRateDec[s][1:0]); // [RULE10]
      end
    end
    next_overBudget = chanTotal > tsr_pkg::CHANNEL_BUDGET; // [RULE9]
  end

  // frame position in 16.384 MHz steps, reset by the frame pulse
  always_comb begin
    next_frameState = frameState;
    next_framePos = framePos;
    if (ckiEdge) begin
      case (frameState)
        FS_HUNT: begin
          if (framePulseIn) begin
            next_frameState = FS_LOCK;
            next_framePos = 11'h000; // [RULE17]
          end
        end
        FS_LOCK: begin
          if (framePulseIn) begin
            next_framePos = 11'h000; // [RULE17]
          end else begin
            next_framePos = framePos + posStep[10:0];
          end
        end
        default: next_frameState = FS_HUNT;
      endcase
    end
  end

  // frame timing registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frameState <= FS_HUNT;
      framePos <= 11'h000;
      ckiPrev <= 1'b0;
      overBudget <= 1'b0;
    end else begin
      frameState <= next_frameState;
      framePos <= next_framePos;
      ckiPrev <= inputBitClock;
      overBudget <= next_overBudget;
    end
  end

  // per-stream input capture and output selection
  for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_stream
    logic [2:0] inRate, outRate;
    logic [2:0] inSh, outSh;
    logic [11:0] posNext;
    logic inBitEnd;
    logic [10:0] inBitNum, outBitNum;
    logic [15:0] entry;
    logic [7:0] outByte;

    assign inRate = rateDec(streamInCtrlRegs[s][tsr_pkg::RATE_LSB +: 4]); // [RULE6] [RULE1]
    assign inRateDec[s] = inRate;
    assign outRate = rateDec(streamOutCtrlRegs[s][tsr_pkg::RATE_LSB +: 4]); // [RULE7] [RULE1]
    assign inSh = 3'h3 - {1'b0, inRate[1:0]};
    assign outSh = 3'h3 - {1'b0, outRate[1:0]};
    // bidir groups read the pin, the separate input stays tied low
    if (s < HALF) begin : g_low
      assign inEff[s] = lowBidir ? serialOutStreamsIn[s] : serialInStreams[s]; // [RULE3]
    end else begin : g_high
      assign inEff[s] = highBidir ? serialOutStreamsIn[s] : serialInStreams[s]; // [RULE4]
    end
    // sample on the last input clock edge of each bit
    assign posNext = {1'b0, framePos} + posStep;
    assign inBitNum = framePos >> inSh;
    assign inBitEnd = ckiEdge && !framePulseIn && frameState == FS_LOCK && inRate[2] &&
                      ((posNext >> inSh) != {1'b0, inBitNum}); // [RULE17]
    assign next_inShift[s] = inBitEnd ? {inShift[s][6:0], inEff[s]} : inShift[s];
    assign memWr[s] = inBitEnd && inBitNum[2:0] == 3'h7;
    assign memWrByte[s] = {inShift[s][6:0], inEff[s]};
    assign memWrIdx[s] = inBitNum[CMW+2:3];
    // output channel and bit at the output rate
    assign outBitNum = framePos >> outSh;
    assign outChan[s] = outBitNum[10:3]; // [RULE2] [RULE12]
    assign entry = connMem[outChan[s][CMW-1:0]];
    assign outByte = entry[tsr_pkg::CM_MSG_BIT] ? entry[7:0] : // [RULE16]
                     dataMem[{entry[tsr_pkg::CM_SRC_LSB +: 5], entry[CMW-1:0]}]; // [RULE8]
    assign outBit[s] = outByte[3'h7 - outBitNum[2:0]];
    // divided slave limits the rate to half the input clock
    assign outOk[s] = outRate[2] && frameState == FS_LOCK &&
                      (multMode || ({1'b0, outRate[1:0]} <= 3'h2 - {1'b0, ckinSel})); // [RULE18] [RULE20]
    assign chanHiz[s] = entry[tsr_pkg::CM_HIZ_BIT] || !outOk[s];
    assign next_serialOutStreams[s] = outOk[s] ? outBit[s] : 1'b0;
    assign next_serialOutStreamsOe[s] = drvEnable && !chanHiz[s]; // [RULE14]
    if (s < NUM_HIZ) begin : g_hiz
      assign next_extHizCtrlOutputs[s] = !drvEnable || chanHiz[s]; // [RULE11] [RULE15]
    end
  end

  // captured bytes and serial output registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int s = 0; s < NUM_STREAMS; s++) begin
        inShift[s] <= 8'h00;
      end
      serialOutStreams <= '0;
      serialOutStreamsOe <= '0;
      extHizCtrlOutputs <= '1; // [RULE14]
    end else begin
      inShift <= next_inShift;
      for (int s = 0; s < NUM_STREAMS; s++) begin
        if (memWr[s]) dataMem[s*CM_DEPTH + int'(memWrIdx[s])] <= memWrByte[s];
      end
      serialOutStreams <= next_serialOutStreams;
      serialOutStreamsOe <= next_serialOutStreamsOe;
      extHizCtrlOutputs <= next_extHizCtrlOutputs;
    end
  end

  // checks beside the logic
  sequence s_frameStart;
    ckiEdge && framePulseIn;
  endsequence
  sequence s_offGate;
    !(outputDriveEnablePin && mainControlReg[tsr_pkg::OSB_BIT]);
  endsequence

  property p_off_forces_safe;
    @(posedge clk) disable iff (!rst_n)
      s_offGate |=> (extHizCtrlOutputs == '1) && (serialOutStreamsOe == '0);
  endproperty
  a_off_forces_safe: assert property (p_off_forces_safe) else $error("outputs not safe"); // [RULE14]

  property p_active_needs_gate;
    @(posedge clk) disable iff (!rst_n)
      (extHizCtrlOutputs != '1) |->
        $past(outputDriveEnablePin && mainControlReg[tsr_pkg::OSB_BIT]);
  endproperty
  a_active_needs_gate: assert property (p_active_needs_gate) else $error("hiz active w/o gate"); // [RULE13]

  property p_frame_boundary;
    @(posedge clk) disable iff (!rst_n)
      s_frameStart |=> (framePos == 11'h000) && (frameState == FS_LOCK);
  endproperty
  a_frame_boundary: assert property (p_frame_boundary) else $error("frame not restarted"); // [RULE17]

  property p_bad_code_off;
    @(posedge clk) disable iff (!rst_n)
      (rateDec(streamOutCtrlRegs[0][3:0]) == 3'h0) |=> !serialOutStreamsOe[0];
  endproperty
  a_bad_code_off: assert property (p_bad_code_off) else $error("disabled stream driven"); // [RULE22]

  property p_divided_limit;
    @(posedge clk) disable iff (!rst_n)
      (!multMode && ckinSel == 2'b10 && streamOutCtrlRegs[0][3:0] == tsr_pkg::RATE_4M)
        |=> !serialOutStreamsOe[0];
  endproperty
  a_divided_limit: assert property (p_divided_limit) else $error("rate above half cki"); // [RULE18]

  property p_unused_hiz;
    @(posedge clk) disable iff (!rst_n)
      chanHiz[0] |=> extHizCtrlOutputs[0] && !serialOutStreamsOe[0];
  endproperty
  a_unused_hiz: assert property (p_unused_hiz) else $error("unused channel not hiz"); // [RULE15]

  property p_slow_channels;
    @(posedge clk) disable iff (!rst_n)
      (streamOutCtrlRegs[0][3:0] == tsr_pkg::RATE_2M) |-> (outChan[0] < 8'd32);
  endproperty
  a_slow_channels: assert property (p_slow_channels) else $error("too many channels"); // [RULE2]

  property p_low_bidir_input;
    @(posedge clk) disable iff (!rst_n)
      lowBidir && !highBidir |-> inEff[0] == serialOutStreamsIn[0] &&
                                 inEff[HALF] == serialInStreams[HALF];
  endproperty
  a_low_bidir_input: assert property (p_low_bidir_input) else $error("group select wrong"); // [RULE5]

  property p_budget_flag;
    @(posedge clk) disable iff (!rst_n)
      (chanTotal > tsr_pkg::CHANNEL_BUDGET) ##1 (chanTotal > tsr_pkg::CHANNEL_BUDGET)
        |-> overBudget;
  endproperty
  a_budget_flag: assert property (p_budget_flag) else $error("budget flag missing"); // [RULE9]

  property p_msg_bit;
    @(posedge clk) disable iff (!rst_n)
      (outOk[0] && g_stream[0].entry[tsr_pkg::CM_MSG_BIT])
        |=> serialOutStreams[0] == $past(g_stream[0].entry[3'h7 - g_stream[0].outBitNum[2:0]]);
  endproperty
  a_msg_bit: assert property (p_msg_bit) else $error("message byte not sent"); // [RULE16]

  property p_ack_pulse;
    @(posedge clk) disable iff (!rst_n)
      wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held"); // [RULE21]
endmodule : tsr_stream_ctrl

/* File: tb/tsr_tdm_partner.sv */
// far-side tdm device model: bit clock, frame pulse and serial input data
`timescale 1ns/1ps
module tsr_tdm_partner #(
  parameter int FRAME_EDGES = 2048
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic inputBitClock,
  output logic framePulseIn,
  output logic [31:0] serialInStreams,
  output logic [31:0] farDrive,
  output logic [11:0] pos
);
  // bit clock at half the system rate, pulse on the first rising edge of a frame
  always @(posedge clk) begin
    if (!rst_n) begin
      inputBitClock <= 1'b0;
      framePulseIn <= 1'b0;
      serialInStreams <= 32'h00000000;
      farDrive <= 32'h00000000;
      pos <= 12'h000;
    end else begin
      farDrive <= ~farDrive; // released two-way pins never show a stale level
      inputBitClock <= ~inputBitClock;
      if (!inputBitClock) begin
        framePulseIn <= (pos == 12'(FRAME_EDGES - 1));
        pos <= (pos == 12'(FRAME_EDGES - 1)) ? 12'h000 : pos + 12'h001;
        serialInStreams <= {32{pos[3]}} ^ 32'h0f0f3c3c;
      end
    end
  end
endmodule : tsr_tdm_partner

/* File: tb/tsr_stream_ctrl_bench.sv */
// self-checking bench for the stream rate and high-impedance control block
`timescale 1ns/1ps
module tsr_stream_ctrl_bench;
  logic clk, rst_n, wbCyc, wbStb, wbWe, wbAck, driveEn, bitClk, framePulse, active;
  logic [3:0] wbSel;
  logic [13:0] wbAdr;
  logic [31:0] wbDatI, wbDatO, rd, serIn, farDrive, outData, outOe, pinLevel;
  logic [15:0] hiz;
  logic [11:0] pos;
  int fails, tests_run;
  int codes[7] = '{0, 1, 2, 3, 4, 5, 15};
  logic [7:0] msg = 8'hab;

  // two-way pin level: dut data while its enable is high, far-side drive otherwise
  assign pinLevel = (outOe & outData) | (~outOe & farDrive);

  tsr_stream_ctrl dut (.clk(clk), .rst_n(rst_n), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbSel(wbSel), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .inputBitClock(bitClk), .framePulseIn(framePulse), .outputDriveEnablePin(driveEn),
    .serialInStreams(serIn), .serialOutStreamsIn(pinLevel), .serialOutStreams(outData),
    .serialOutStreamsOe(outOe), .extHizCtrlOutputs(hiz));
  tsr_tdm_partner partner (.clk(clk), .rst_n(rst_n), .inputBitClock(bitClk),
    .framePulseIn(framePulse), .serialInStreams(serIn), .farDrive(farDrive), .pos(pos));

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t ns %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  // counts, verdict and end of run
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  // one classic wishbone cycle, held until ack is sampled
  task automatic wb_cycle(input logic we, input logic [11:0] adr, input logic [15:0] dat);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'h3;
    wbAdr <= {2'b00, adr};
    wbDatI <= {16'h0000, dat};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (n >= 50) begin
      fails++;
      complete_run();
    end
  endtask : wb_cycle

  task automatic wr(input logic [11:0] adr, input logic [15:0] dat);
    wb_cycle(1'b1, adr, dat);
  endtask : wr

  task automatic rd_check(input logic [11:0] adr, input logic [15:0] exp, input string what);
    wb_cycle(1'b0, adr, 16'h0000);
    check(rd, {16'h0000, exp}, what);
  endtask : rd_check

  // wait for a frame position, then let the two-clock output latency pass
  task automatic at_pos(input int p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pos != 12'(p) && n < 10000);
    if (n >= 10000) begin
      fails++;
      complete_run();
    end
    @(posedge clk);
    #1;
  endtask : at_pos

  // main sequence
  initial begin
    rst_n = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbSel = 4'h0;
    wbAdr = 14'h0000;
    wbDatI = 32'h00000000;
    driveEn = 1'b0;
    fails = 0;
    tests_run = 0;
    repeat (4) @(posedge clk);
    check({16'h0000, hiz}, 32'h0000ffff, "hiz in reset");
    check(outOe, 32'h00000000, "oe in reset");
    rst_n <= 1'b1;
    rd_check(tsr_pkg::MAIN_CTRL_OFS, tsr_pkg::MAIN_CTRL_RST, "control reset");
    rd_check(tsr_pkg::MODE_SEL_OFS, tsr_pkg::MODE_SEL_RST, "mode reset");
    rd_check(tsr_pkg::IN_CTRL_BASE, tsr_pkg::STREAM_CTRL_RST, "in ctrl reset");
    rd_check(tsr_pkg::OUT_CTRL_BASE, tsr_pkg::STREAM_CTRL_RST, "out ctrl reset");
    rd_check(tsr_pkg::CONN_MEM_BASE, tsr_pkg::CONN_MEM_RST, "cm reset");
    rd_check(12'h0fc, 16'h0000, "unmapped read");
    $display("test reset done");
    // message byte on stream 0, streams 0 and 1 at the slowest rate
    driveEn <= 1'b1;
    wr(tsr_pkg::MAIN_CTRL_OFS, 16'h000c);
    wr(tsr_pkg::CONN_MEM_BASE, 16'h40ab);
    wr(tsr_pkg::OUT_CTRL_BASE, {12'h000, tsr_pkg::RATE_2M});
    wr(tsr_pkg::OUT_CTRL_BASE + 12'h004, {12'h000, tsr_pkg::RATE_2M});
    at_pos(2047);
    for (int i = 0; i < 8; i++) begin
      at_pos(8 * i + 4);
      check(outData[0], msg[7 - i], "message bit");
    end
    at_pos(60);
    check({outOe[1:0], hiz[1:0]}, 4'b1100, "channel 0 driven");
    at_pos(96);
    check({outOe[0], hiz[0]}, 2'b01, "unused channel");
    $display("test message done");
    // the four rate codes and codes 0, 5 and 15 on stream 0, stream 1 held at the slowest rate
    foreach (codes[j]) begin
      active = codes[j] >= 1 && codes[j] <= 4;
      wr(tsr_pkg::OUT_CTRL_BASE, 16'(codes[j]));
      at_pos(4);
      check(hiz[0], !active, "rate code enable");
      at_pos(48);
      check(hiz[1:0], {1'b0, codes[j] != 1}, "channel length");
    end
    $display("test rates done");
    // divided mode: output rate no higher than half the input clock
    wr(tsr_pkg::MAIN_CTRL_OFS, 16'h0004);
    wr(tsr_pkg::OUT_CTRL_BASE, {12'h000, tsr_pkg::RATE_16M});
    at_pos(4);
    check(outOe[0], 1'b0, "divided too fast");
    wr(tsr_pkg::OUT_CTRL_BASE, {12'h000, tsr_pkg::RATE_8M});
    at_pos(4);
    check(outOe[0], 1'b1, "divided at limit");
    // slowest input clock select: only the slowest output rate may run
    wr(tsr_pkg::MAIN_CTRL_OFS, 16'h0044);
    wr(tsr_pkg::OUT_CTRL_BASE, {12'h000, tsr_pkg::RATE_4M});
    at_pos(1);
    check(outOe[0], 1'b0, "slow clock too fast");
    wr(tsr_pkg::OUT_CTRL_BASE, {12'h000, tsr_pkg::RATE_2M});
    at_pos(1);
    check(outOe[0], 1'b1, "slow clock at limit");
    wr(tsr_pkg::MAIN_CTRL_OFS, 16'h0014);
    wb_cycle(1'b0, tsr_pkg::STATUS_OFS, 16'h0000);
    check(rd[14:13], 2'b11, "core clock select");
    $display("test divided done");
    // drive enable pin low, then standby bit low
    @(posedge clk);
    driveEn <= 1'b0;
    at_pos(8);
    check({16'h0000, hiz}, 32'h0000ffff, "pin low hiz");
    check(outOe, 32'h00000000, "pin low oe");
    @(posedge clk);
    driveEn <= 1'b1;
    wr(tsr_pkg::MAIN_CTRL_OFS, 16'h0010);
    at_pos(8);
    check({16'h0000, hiz}, 32'h0000ffff, "standby low hiz");
    check(outOe, 32'h00000000, "standby low oe");
    $display("test gating done");
    // channel total of enabled input streams, then over budget
    wr(tsr_pkg::IN_CTRL_BASE, {12'h000, tsr_pkg::RATE_16M});
    wr(tsr_pkg::IN_CTRL_BASE + 12'h004, {12'h000, tsr_pkg::RATE_2M});
    wr(tsr_pkg::STATUS_OFS, 16'hffff);
    wb_cycle(1'b0, tsr_pkg::STATUS_OFS, 16'h0000);
    check({rd[15], rd[12:0]}, 14'h0120, "channel total");
    for (int k = 2; k < 10; k++) begin
      wr(tsr_pkg::IN_CTRL_BASE + 12'(4 * k), {12'h000, tsr_pkg::RATE_16M});
    end
    wb_cycle(1'b0, tsr_pkg::STATUS_OFS, 16'h0000);
    check({rd[15], rd[12:0]}, 14'h2920, "over budget");
    // switched data: stream 0 in at the fastest rate, out at the slowest
    // odd input channels carry all ones, even ones all zeros
    wr(tsr_pkg::MAIN_CTRL_OFS, 16'h000c);
    wr(tsr_pkg::CONN_MEM_BASE, 16'h0001);
    at_pos(12);
    check({outOe[0], outData[0]}, 2'b11, "switched odd channel");
    wr(tsr_pkg::CONN_MEM_BASE, 16'h0000);
    at_pos(20);
    check({outOe[0], outData[0]}, 2'b10, "switched even channel");
    // bidirectional groups set independently
    wr(tsr_pkg::MODE_SEL_OFS, 16'h00c0);
    rd_check(tsr_pkg::MODE_SEL_OFS, 16'h00c0, "both groups");
    wr(tsr_pkg::MODE_SEL_OFS, 16'h0040);
    rd_check(tsr_pkg::MODE_SEL_OFS, 16'h0040, "low group only");
    $display("test status and mode done");
    complete_run();
  end
endmodule : tsr_stream_ctrl_bench
